/* File: verilog/rsf_reset_cause.sv */
// Reset source sequencer and reset cause register.
`timescale 1ns/100ps
// Function
// R1: Cause register sits at 0xEF, eight bits; bit 5 reads zero, writes ignored.
// R2: Writing bit 7 enables USB as a reset source; read shows USB cause.
// R3: Bit 7 reads one only if USB caused the last reset.
// R4: Bit 6 is read-only and flags a program-memory address error reset.
// R5: Writing one to bit 4 forces a full system reset at once.
// R6: Bit 4 reads one only after a software forced reset.
// R7: Bit 3 is read-only and flags a watchdog overflow reset.
// R8: Writing one to bit 2 arms the clock loss detector as reset source.
// R9: Bit 2 reads one after a clock loss timeout reset.
// R10: Writing one to bit 1 enables the supply monitor as reset source.
// R11: Software enables and settles the supply monitor before setting bit 1.
// R12: Bit 1 reads one after power-on or supply reset; others then untrusted.
// R13: Bit 0 is read-only and flags an external pin reset.
// R14: Software writes whole bytes, never read-modify-write, to this register.
// R15: Clock loss one-shot fires when the watched clock stalls past timeout.
// R16: After any reset the watchdog is enabled and clocked at clock/12.
// R17: USB source resets on bus reset or a bus power edge of chosen polarity.
// R18: Program-memory access above user space resets and sets the memory flag.
// R19: Each reset latches its cause, clears others, holds flags until next reset.
// R20: Simultaneous causes merge into one reset pulse recording every cause.
module rsf_reset_cause (
    input wire logic mclk, // System clock, 20 MHz.
    input wire logic rstn, // Power-on reset, asynchronous, active low.
    input wire logic [7:0] sfr_addr, // Special-function register address.
    input wire logic sfr_wr, // Write strobe, one cycle.
    input wire logic sfr_rd, // Read strobe, one cycle.
    input wire logic [7:0] sfr_wdata, // Write data.
    output logic [7:0] sfr_rdata, // Read data, valid the cycle after sfr_rd.
    input wire logic pin_reset_n, // External reset pin, active low.
    input wire logic supply_monitor_enable, // Supply monitor circuit is on.
    input wire logic supply_low, // Supply at or below monitor threshold.
    input wire logic watchdog_overflow, // Watchdog overflow pulse.
    input wire logic watchdog_off, // Software disabled the watchdog.
    input wire logic mem_addr_error, // Illegal program-memory access pulse.
    input wire logic usb_bus_reset, // Bus reset signaling detected.
    input wire logic vbus_level, // Bus power detector level.
    input wire logic bus_power_edge_polarity, // 1 rising, 0 falling edge.
    input wire logic clk_activity, // Level that follows the watched clock.
    output logic sys_reset, // System reset, active high.
    output logic watchdog_enable, // Watchdog enabled.
    output logic watchdog_tick // Watchdog prescaled clock pulse.
);
    typedef struct packed {
        rsf_pkg::rsf_state_e st;
        logic [7:0] hold_cnt;
        logic [7:0] capture;
        logic [7:0] flags;
        logic usb_en;
        logic loss_en;
        logic supply_en;
        logic watchdog_en;
        logic [3:0] watchdog_div;
        logic watchdog_tick;
        logic vbus_prev;
        logic sys_reset;
        logic [7:0] rdata;
    } rsf_main_s;

    // Power-on puts the block in the hold state with the power flag set.
    localparam rsf_main_s RESET_STATE = '{
        st: rsf_pkg::RSF_HOLD,
        hold_cnt: 8'h00,
        capture: rsf_pkg::FLAGS_RESET,
        flags: rsf_pkg::FLAGS_RESET,
        usb_en: 1'b0,
        loss_en: 1'b0,
        supply_en: 1'b1,
        watchdog_en: 1'b1,
        watchdog_div: 4'h0,
        watchdog_tick: 1'b0,
        vbus_prev: 1'b0,
        sys_reset: 1'b1,
        rdata: 8'h00
    };

    rsf_main_s s_q;
    rsf_main_s s_d;
    logic loss;
    logic hit_wr;
    logic hit_rd;
    logic vbus_edge;
    logic level_cause;
    logic [7:0] causes;
    logic [7:0] read_value;

    // Clock loss one-shot, armed by the enable bit of the register.
    rsf_clock_loss u_loss (
        .mclk(mclk),
        .rstn(rstn),
        .enable(s_q.loss_en),
        .clk_activity(clk_activity),
        .loss(loss)
    );

    // Register decode; writes are refused while the system is held in reset.
    assign hit_wr = sfr_wr && sfr_addr == rsf_pkg::CAUSE_ADDR && s_q.st == rsf_pkg::RSF_RUN;
    assign hit_rd = sfr_rd && sfr_addr == rsf_pkg::CAUSE_ADDR;

    // Bit 5 has no storage and always reads zero.
    assign read_value = {s_q.flags[7:6], 1'b0, s_q.flags[4:0]}; // R1

    // Bus power edge matching the configured polarity.
    assign vbus_edge = bus_power_edge_polarity ? (vbus_level && !s_q.vbus_prev)
                                               : (!vbus_level && s_q.vbus_prev); // R17

    // Qualified reset causes, one bit per flag position.
    always_comb begin
        causes = 8'h00;
        causes[rsf_pkg::USB_BIT] = s_q.usb_en && (usb_bus_reset || vbus_edge); // R17
        causes[rsf_pkg::MEM_BIT] = mem_addr_error; // R18
        causes[rsf_pkg::SOFT_BIT] = hit_wr && sfr_wdata[rsf_pkg::SOFT_BIT]; // R5
        causes[rsf_pkg::WATCHDOG_BIT] = s_q.watchdog_en && watchdog_overflow; // R7
        causes[rsf_pkg::LOSS_BIT] = loss; // R8
        causes[rsf_pkg::POWER_BIT] = s_q.supply_en && supply_monitor_enable && supply_low; // R10
        causes[rsf_pkg::PIN_BIT] = !pin_reset_n; // R13
    end

    // Pin and supply causes are levels: the reset lasts as long as they do.
    assign level_cause = causes[rsf_pkg::PIN_BIT] || causes[rsf_pkg::POWER_BIT];

    // Next-state logic for the whole block.
    always_comb begin
        s_d = s_q;
        s_d.vbus_prev = vbus_level;
        s_d.watchdog_tick = 1'b0;
        s_d.rdata = hit_rd ? read_value : 8'h00;
        // Watchdog prescaler runs from every reset onward.
        if (s_q.watchdog_div == rsf_pkg::WATCHDOG_DIV - 4'h1) begin
            s_d.watchdog_div = 4'h0;
            s_d.watchdog_tick = s_q.watchdog_en; // R16
        end else begin
            s_d.watchdog_div = s_q.watchdog_div + 4'h1;
        end
        if (watchdog_off && s_q.st == rsf_pkg::RSF_RUN) begin
            s_d.watchdog_en = 1'b0;
        end
        case (s_q.st)
            rsf_pkg::RSF_RUN: begin
                if (|causes) begin
                    // Every cause of this cycle goes into one pulse.
                    s_d.st = rsf_pkg::RSF_HOLD;
                    s_d.hold_cnt = 8'h00;
                    s_d.capture = causes; // R20
                    s_d.sys_reset = 1'b1; // R5
                    s_d.usb_en = 1'b0;
                    s_d.loss_en = 1'b0;
                    s_d.supply_en = 1'b1;
                    s_d.watchdog_en = 1'b1; // R16
                    s_d.watchdog_div = 4'h0; // R16
                end else if (hit_wr) begin
                    // Enables take the written bits; bits 6, 5, 3, 0 are ignored.
                    s_d.usb_en = sfr_wdata[rsf_pkg::USB_BIT]; // R2
                    s_d.loss_en = sfr_wdata[rsf_pkg::LOSS_BIT]; // R8
                    s_d.supply_en = sfr_wdata[rsf_pkg::POWER_BIT]; // R10
                end
            end
            rsf_pkg::RSF_HOLD: begin
                // Late causes during the pulse are merged, save in its last cycle, where they miss the flags and are lost.
                s_d.capture = s_q.capture | causes; // R20
                if (s_q.hold_cnt != rsf_pkg::HOLD_CYC - 8'h01) begin
                    s_d.hold_cnt = s_q.hold_cnt + 8'h01;
                end else if (!level_cause) begin
                    // Flags change only on leaving reset, so software never
                    // sees a half-written cause set.
                    s_d.st = rsf_pkg::RSF_RUN;
                    s_d.sys_reset = 1'b0;
                    s_d.flags = s_q.capture; // R3 R4 R6 R9 R19
                end
            end
            default: begin
                s_d.st = rsf_pkg::RSF_HOLD;
                s_d.sys_reset = 1'b1;
            end
        endcase
    end

    // State register.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= RESET_STATE; // R12
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign sfr_rdata = s_q.rdata;
    assign sys_reset = s_q.sys_reset;
    assign watchdog_enable = s_q.watchdog_en;
    assign watchdog_tick = s_q.watchdog_tick;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // Read returns the flags with bit 5 forced low.
    property p_read_map;
        hit_rd |=> sfr_rdata[5] == 1'b0 && sfr_rdata[4:0] == $past(s_q.flags[4:0]);
    endproperty
    a_read_map: assert property (p_read_map) else $error("bad read data"); // R1

    property p_usb_enable;
        (hit_wr && causes == 8'h00) |=> s_q.usb_en == $past(sfr_wdata[7]);
    endproperty
    a_usb_enable: assert property (p_usb_enable) else $error("usb enable not stored"); // R2

    property p_usb_cause;
        (s_q.st == rsf_pkg::RSF_RUN && s_q.usb_en && usb_bus_reset)
            |=> sys_reset && s_q.capture[7];
    endproperty
    a_usb_cause: assert property (p_usb_cause) else $error("usb reset missed"); // R3

    property p_mem_cause;
        (s_q.st == rsf_pkg::RSF_RUN && mem_addr_error) |=> sys_reset && s_q.capture[6];
    endproperty
    a_mem_cause: assert property (p_mem_cause) else $error("memory error reset missed"); // R4

    property p_soft_force;
        (hit_wr && sfr_wdata[4]) |=> sys_reset && s_q.capture[4];
    endproperty
    a_soft_force: assert property (p_soft_force) else $error("software reset missed"); // R6

    property p_watchdog_cause;
        (s_q.st == rsf_pkg::RSF_RUN && s_q.watchdog_en && watchdog_overflow)
            |=> s_q.capture[3];
    endproperty
    a_watchdog_cause: assert property (p_watchdog_cause) else $error("watchdog cause lost"); // R7

    property p_loss_cause;
        (s_q.st == rsf_pkg::RSF_RUN && loss) |=> sys_reset && s_q.capture[2];
    endproperty
    a_loss_cause: assert property (p_loss_cause) else $error("clock loss cause lost"); // R9

    property p_pin_cause;
        (!pin_reset_n) |=> sys_reset && s_q.capture[0];
    endproperty
    a_pin_cause: assert property (p_pin_cause) else $error("pin reset missed"); // R13

    property p_pulse_len;
        $rose(sys_reset) |-> sys_reset [*4];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("reset pulse too short"); // R20

    property p_latch;
        $fell(sys_reset) |-> s_q.flags == $past(s_q.capture);
    endproperty
    a_latch: assert property (p_latch) else $error("flags not latched"); // R19

    property p_flags_stable;
        !$fell(sys_reset) |-> $stable(s_q.flags);
    endproperty
    a_flags_stable: assert property (p_flags_stable) else $error("flags moved"); // R19

    property p_watchdog_rate;
        watchdog_tick |=> !watchdog_tick [*8];
    endproperty
    a_watchdog_rate: assert property (p_watchdog_rate) else $error("prescale too fast"); // R16

    property p_watchdog_on;
        $rose(sys_reset) |-> watchdog_enable;
    endproperty
    a_watchdog_on: assert property (p_watchdog_on) else $error("watchdog off after reset"); // R16

    // A read that misses the register leaves the data lines at zero.
    property p_rdata_idle;
        !hit_rd |=> sfr_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared"); // R1

    // An accepted write with no cause stores the clock loss and supply enables.
    property p_enable_store;
        (hit_wr && causes == 8'h00)
            |=> s_q.loss_en == $past(sfr_wdata[2]) && s_q.supply_en == $past(sfr_wdata[1]);
    endproperty
    a_enable_store: assert property (p_enable_store) else $error("enable not stored"); // R8 R10

    // A qualified low supply starts a reset and records the power flag.
    property p_supply_cause;
        (s_q.st == rsf_pkg::RSF_RUN && s_q.supply_en && supply_monitor_enable && supply_low)
            |=> sys_reset && s_q.capture[1];
    endproperty
    a_supply_cause: assert property (p_supply_cause) else $error("supply reset missed"); // R10

    // A disabled watchdog gets no prescaled pulses.
    property p_tick_gate;
        !watchdog_enable |=> !watchdog_tick;
    endproperty
    a_tick_gate: assert property (p_tick_gate) else $error("tick while watchdog off"); // R16

    // Entry clears the USB and clock loss sources so they cannot retrigger the pulse.
    property p_entry_enables;
        $rose(sys_reset) |-> !s_q.usb_en && !s_q.loss_en && s_q.supply_en;
    endproperty
    a_entry_enables: assert property (p_entry_enables) else $error("enables not reset"); // R8 R17

    // Main scenarios worth seeing at least once.
    c_soft: cover property ((hit_wr && sfr_wdata[4]) ##[1:20] $fell(sys_reset));
    c_loss: cover property ($fell(sys_reset) && s_q.flags[2]);
    c_usb: cover property (s_q.usb_en && vbus_edge && s_q.st == rsf_pkg::RSF_RUN);
    c_multi: cover property ($fell(sys_reset) && $countones(s_q.flags) > 1);
endmodule

/* File: verilog/rsf_pkg.sv */
// Constants and types shared by the reset source logic.
package rsf_pkg;
    // Location of the reset cause register on the special-function bus.
    localparam logic [7:0] CAUSE_ADDR = 8'hef;

    // Bit positions inside the reset cause register.
    localparam int USB_BIT = 7;
    localparam int MEM_BIT = 6;
    localparam int UNUSED_BIT = 5;
    localparam int SOFT_BIT = 4;
    localparam int WATCHDOG_BIT = 3;
    localparam int LOSS_BIT = 2;
    localparam int POWER_BIT = 1;
    localparam int PIN_BIT = 0;

    // Flags after power-on: only the power-on flag reads as set.
    localparam logic [7:0] FLAGS_RESET = 8'h02;

    // System clock period and the clock loss timeout derived from it.
    localparam int CLK_PERIOD_NS = 50;
    localparam int LOSS_TIMEOUT_NS = 500;
    localparam logic [7:0] LOSS_TIMEOUT_CYC = 8'(LOSS_TIMEOUT_NS / CLK_PERIOD_NS);

    // Shortest length of the combined system reset pulse, in cycles.
    localparam logic [7:0] HOLD_CYC = 8'h04;

    // Watchdog prescale ratio after any reset.
    localparam logic [3:0] WATCHDOG_DIV = 4'hc;

    // Sequencer states.
    typedef enum logic {RSF_RUN, RSF_HOLD} rsf_state_e;
endpackage

/* File: verilog/rsf_clock_loss.sv */
// One-shot clock loss detector retriggered by every edge of the watched clock.
`timescale 1ns/100ps
module rsf_clock_loss (
    input wire logic mclk, // Free-running reference clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic enable, // Detector armed by software.
    input wire logic clk_activity, // Level that follows the watched clock.
    output logic loss // One-cycle pulse when the watched clock stalls.
);
    typedef struct packed {
        logic prev;
        logic [7:0] cnt;
        logic loss;
    } rsf_loss_s;

    rsf_loss_s s_q;
    rsf_loss_s s_d;

    // Any change of level retriggers the one-shot, so a clock stuck high
    // and one stuck low are caught alike. The watched level may change at
    // most once per reference cycle or edges are missed.
    always_comb begin
        s_d = s_q;
        s_d.prev = clk_activity;
        s_d.loss = 1'b0;
        if (!enable || clk_activity != s_q.prev) begin
            s_d.cnt = 8'h00;
        end else if (s_q.cnt == rsf_pkg::LOSS_TIMEOUT_CYC - 8'h01) begin
            s_d.cnt = 8'h00;
            s_d.loss = 1'b1; // R15
        end else begin
            s_d.cnt = s_q.cnt + 8'h01;
        end
    end

    // State register.
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign loss = s_q.loss;

    // Timeout at the counted figure while armed and the level is stuck.
    property p_timeout;
        @(posedge mclk) disable iff (!rstn)
        (enable && clk_activity == s_q.prev
            && s_q.cnt == rsf_pkg::LOSS_TIMEOUT_CYC - 8'h01) |=> loss;
    endproperty
    a_timeout: assert property (p_timeout) else $error("clock loss not flagged"); // R15

    property p_no_false_loss;
        @(posedge mclk) disable iff (!rstn)
        (clk_activity != s_q.prev) |=> !loss;
    endproperty
    a_no_false_loss: assert property (p_no_false_loss) else $error("loss on live clock"); // R15
endmodule

/* File: test/rsf_reset_cause_tb_top.sv */
// Self-checking testbench for the reset source sequencer and its cause register.
`timescale 1ns/100ps
`define CHK(got, exp, msg) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("wrong value at %0t: %s", $time, msg); \
    end \
end
module rsf_reset_cause_tb_top;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic pin_reset_n = 1'b1;
    logic supply_low = 1'b0;
    logic supply_mon_on = 1'b1;
    logic [2:0] ev = 3'h0; // Bus reset, watchdog overflow, memory error.
    logic watchdog_off = 1'b0;
    logic vbus_level = 1'b0;
    logic bus_power_edge_polarity = 1'b1;
    logic clk_activity = 1'b0;
    logic act_run = 1'b1;
    logic sys_reset;
    logic watchdog_enable;
    logic watchdog_tick;
    logic [7:0] rd;
    int n_mismatch = 0;
    int compares = 0;

    rsf_reset_cause i_dut (
        .mclk(mclk), .rstn(rstn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .pin_reset_n(pin_reset_n),
        .supply_monitor_enable(supply_mon_on), .supply_low(supply_low),
        .watchdog_overflow(ev[1]), .watchdog_off(watchdog_off), .mem_addr_error(ev[0]),
        .usb_bus_reset(ev[2]), .vbus_level(vbus_level),
        .bus_power_edge_polarity(bus_power_edge_polarity), .clk_activity(clk_activity),
        .sys_reset(sys_reset), .watchdog_enable(watchdog_enable), .watchdog_tick(watchdog_tick)
    );

    // Free-running 20 MHz system clock.
    initial begin
        forever #25 mclk = ~mclk;
    end

    // The watched clock toggles every cycle; stopping it models a stalled oscillator.
    always @(posedge mclk) begin
        #1;
        if (act_run) begin
            clk_activity = ~clk_activity;
        end
    end

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One register write; the strobe drops an edge later so back-to-back calls stay clean.
    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk) #1;
        sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        @(posedge mclk) #1;
        sfr_wr = 1'b0;
    endtask

    // One register read; data stands only in the cycle after the strobe is taken.
    task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge mclk) #1;
        sfr_addr = addr;
        sfr_rd = 1'b1;
        @(posedge mclk) #1;
        sfr_rd = 1'b0;
        data = sfr_rdata;
    endtask

    // Pulses the selected cause inputs for one cycle.
    task automatic fire(input logic [2:0] e);
        @(posedge mclk) #1;
        ev = e;
        @(posedge mclk) #1;
        ev = 3'h0;
    endtask

    // Checks that no system reset appears for n cycles.
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge mclk) #1;
            `CHK(sys_reset, 1'b0, "reset without a cause")
        end
    endtask

    // Waits for a reset pulse, checks its length when len is nonzero, then the flags.
    task automatic expect_reset(input int len, input logic [7:0] flags);
        int n;
        for (n = 0; n < 40 && sys_reset !== 1'b1; n++) begin
            @(posedge mclk) #1;
        end
        `CHK(sys_reset, 1'b1, "no reset pulse")
        n = 0;
        while (sys_reset === 1'b1 && n < 100) begin
            @(posedge mclk) #1;
            n++;
        end
        if (len > 0) begin
            `CHK(n, len, "reset pulse length")
        end
        sfr_read(rsf_pkg::CAUSE_ADDR, rd);
        `CHK(rd, flags, "cause flags")
    endtask

    // Measures the spacing of two watchdog prescaler pulses.
    task automatic tick_period;
        int n;
        for (n = 0; n < 30 && watchdog_tick !== 1'b1; n++) begin
            @(posedge mclk) #1;
        end
        n = 0;
        do begin
            @(posedge mclk) #1;
            n++;
        end while (watchdog_tick !== 1'b1 && n < 30);
        `CHK(n, 12, "watchdog prescale")
    endtask

    // Hang guard, reckoned well above the few hundred cycles the sequence needs.
    initial begin
        #(50 * 5000);
        n_mismatch++;
        test_done();
    end

    // Power-on: reset held for 12 cycles, then a four-cycle pulse with the power flag.
    task automatic t_power_on;
        repeat (12) @(posedge mclk);
        #1 rstn = 1'b1;
        expect_reset(4, 8'h02);
        sfr_read(8'hee, rd);
        `CHK(rd, 8'h00, "unmapped read")
        tick_period();
    endtask

    // Causes that are not enabled or not addressed must not reset the system.
    task automatic t_gated;
        sfr_write(8'hee, 8'h10);
        quiet(6);
        fire(3'h4);
        quiet(6);
        @(posedge mclk) #1 watchdog_off = 1'b1;
        @(posedge mclk) #1 watchdog_off = 1'b0;
        `CHK(watchdog_enable, 1'b0, "watchdog not disabled")
        fire(3'h2);
        quiet(6);
    endtask

    // Software force, then watchdog and memory errors alone and together.
    task automatic t_internal;
        sfr_write(rsf_pkg::CAUSE_ADDR, 8'h30);
        expect_reset(4, 8'h10);
        `CHK(watchdog_enable, 1'b1, "watchdog after reset")
        fire(3'h2);
        expect_reset(4, 8'h08);
        fire(3'h1);
        expect_reset(4, 8'h40);
        fire(3'h3);
        expect_reset(4, 8'h48);
    endtask

    // The pin reset lasts while the pin is low and sets only the pin flag.
    task automatic t_pin;
        @(posedge mclk) #1 pin_reset_n = 1'b0;
        repeat (6) @(posedge mclk);
        #1 pin_reset_n = 1'b1;
        expect_reset(0, 8'h01);
    endtask

    // Low supply resets only while the monitor circuit is on and selected.
    task automatic t_supply;
        sfr_write(rsf_pkg::CAUSE_ADDR, 8'h02);
        supply_mon_on = 1'b0;
        supply_low = 1'b1;
        quiet(4);
        supply_low = 1'b0;
        supply_mon_on = 1'b1;
        @(posedge mclk) #1 supply_low = 1'b1;
        repeat (6) @(posedge mclk);
        #1 supply_low = 1'b0;
        expect_reset(0, 8'h02);
    endtask

    // A stalled watched clock trips the armed detector after its timeout.
    task automatic t_loss;
        sfr_write(rsf_pkg::CAUSE_ADDR, 8'h04);
        quiet(20);
        act_run = 1'b0;
        quiet(7);
        expect_reset(0, 8'h04);
        act_run = 1'b1;
    endtask

    // USB bus reset, then writes to the read-only flags leave the cause alone.
    task automatic t_usb;
        sfr_write(rsf_pkg::CAUSE_ADDR, 8'h80);
        fire(3'h4);
        expect_reset(4, 8'h80);
        sfr_write(rsf_pkg::CAUSE_ADDR, 8'h49);
        sfr_read(rsf_pkg::CAUSE_ADDR, rd);
        `CHK(rd, 8'h80, "read-only flags changed")
    endtask

    // Bus power edges of each polarity reset the system once USB is selected.
    task automatic t_vbus;
        for (int p = 0; p < 2; p++) begin
            bus_power_edge_polarity = p[0];
            vbus_level = ~p[0];
            sfr_write(rsf_pkg::CAUSE_ADDR, 8'h80);
            quiet(2);
            vbus_level = p[0];
            expect_reset(4, 8'h80);
        end
    endtask

    // Main sequence: one scenario after another, then the verdict.
    initial begin
        t_power_on();
        t_gated();
        t_internal();
        t_pin();
        t_supply();
        t_loss();
        t_usb();
        t_vbus();
        test_done();
    end
endmodule
